// ===== rtl/scb_map.svh
// address map, strap table and field positions of the serial control target
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

`define SCB_ADDR_REG   8'h00
`define SCB_REG_COUNT  8
`define SCB_OVR_BIT    0
`define SCB_ADDR_RESET 8'h00
`define STRAP_BASE     7'h0c
`define STRAP_STEP     7'h02
`define STRAP_SETTLE   2'h2
`define BIT_LAST       4'h7
`define BIT_ACK        4'h8
`define BIT_START      4'hf

`endif

// ===== rtl/scb_pkg.sv
// types of the serial control target
package scb_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_OFFS  = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_WAIT  = 3'b101
  } scb_state_t;

endpackage

// ===== rtl/strap_decoder.sv
// samples the address strap after reset and turns it into a bus address
`timescale 1ns/1ns
`include "scb_map.svh"

module strap_decoder (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] address_strap_pin,
  output logic      [6:0] strap_addr_r,
  output logic            strap_valid_r
);

  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [1:0] settle_r;

  function automatic logic [6:0] strap_to_addr(input logic [2:0] code);
    strap_to_addr = `STRAP_BASE + `STRAP_STEP * {4'h0, code};
  endfunction

  // =====================================================================
  // synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
    end else begin
      strap_s1_r <= address_strap_pin;
      strap_s2_r <= strap_s1_r;
    end
  end

  // =====================================================================
  // one capture after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_r      <= 2'h0;
      strap_addr_r  <= 7'h00;
      strap_valid_r <= 1'b0;
    end else if (!strap_valid_r) begin
      if (settle_r == `STRAP_SETTLE) begin
        strap_addr_r  <= strap_to_addr(strap_s2_r);
        strap_valid_r <= 1'b1;
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  property p_strap_hold;
    @(posedge clk) disable iff (!arst_n)
      strap_valid_r |=> strap_valid_r && $stable(strap_addr_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap address changed after capture");

  property p_strap_range;
    @(posedge clk) disable iff (!arst_n)
      $rose(strap_valid_r) |-> strap_addr_r == {3'h0, $past(strap_s2_r), 1'b0} + `STRAP_BASE;
  endproperty
  a_strap_range: assert property (p_strap_range) else $error("strap address not from table");

endmodule

// ===== rtl/serial_control_bus_target.sv
// two-wire serial control target with strap or programmed address
// =====================================================================
// Overview of operation
// - bus address comes from one of eight straps
// - straps map to 0x0C..0x1A in steps two
// - data rising while clock high is stop
// - matching address is acknowledged by pulling data
// - other address leaves data released, not acknowledged
// - each written data byte is acknowledged
// - host not-acknowledge ends read data drive
// - clock line is sensed only, never driven (scl_oe held low)
// - lines are only pulled low or released
// - register 0x00 bits 7:1 hold programmed address
// - bit 0 set selects programmed over strap address
`timescale 1ns/1ns
`include "scb_map.svh"

module serial_control_bus_target
  import scb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] address_strap_pin,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic      [6:0] bus_addr
);

  logic [7:0]  regs_r [`SCB_REG_COUNT];
  logic        scl_s1_r, scl_s2_r, scl_d_r;
  logic        sda_s1_r, sda_s2_r, sda_d_r;
  scb_state_t  state_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shreg_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        host_ack_r;
  logic [6:0]  strap_addr;
  logic        strap_valid;
  logic [6:0]  own_addr;
  logic        scl_rise, scl_fall, start_ev, stop_ev;
  logic        byte_end, ack_end, match, do_ack, load_rd;
  logic [7:0]  rd_byte;

  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] v);
    reg_read = (idx < 8'(`SCB_REG_COUNT)) ? v : 8'h00;
  endfunction

  strap_decoder u_strap (
    .clk               (clk),
    .arst_n            (arst_n),
    .address_strap_pin (address_strap_pin),
    .strap_addr_r      (strap_addr),
    .strap_valid_r     (strap_valid)
  );

  // =====================================================================
  // line synchronisers and edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_ev = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_ev  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // =====================================================================
  // address selection
  assign own_addr = regs_r[0][`SCB_OVR_BIT] ? regs_r[0][7:1] : strap_addr;
  assign match    = (shreg_r[7:1] == own_addr) && (regs_r[0][`SCB_OVR_BIT] || strap_valid);
  assign byte_end = scl_fall && (cnt_r == `BIT_LAST);
  assign ack_end  = scl_fall && (cnt_r == `BIT_ACK);
  assign do_ack   = byte_end && ((state_r == ST_ADDR) ? match
                                 : (state_r == ST_OFFS || state_r == ST_WDATA));
  assign load_rd  = ack_end && ((state_r == ST_ADDR && rw_r) || (state_r == ST_RDATA && host_ack_r));
  assign rd_byte  = reg_read(ptr_r, regs_r[ptr_r[2:0]]);

  // =====================================================================
  // transaction sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 4'h0;
      shreg_r    <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      rw_r       <= 1'b0;
      host_ack_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      cnt_r   <= `BIT_START;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
    end else if (state_r != ST_IDLE && state_r != ST_WAIT) begin
      if (scl_rise && cnt_r < `BIT_ACK)
        shreg_r <= {shreg_r[6:0], sda_s2_r};
      if (scl_rise && cnt_r == `BIT_ACK && state_r == ST_RDATA) begin
        host_ack_r <= ~sda_s2_r;
        if (sda_s2_r)
          state_r <= ST_WAIT;
      end
      if (scl_fall) begin
        cnt_r <= (cnt_r == `BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
        if (state_r == ST_RDATA && cnt_r < `BIT_LAST)
          tx_r <= {tx_r[6:0], 1'b0};
      end
      if (byte_end) begin
        unique case (state_r)
          ST_ADDR: begin
            rw_r <= shreg_r[0];
            if (!match)
              state_r <= ST_WAIT;
          end
          ST_OFFS:  ptr_r <= shreg_r;
          ST_WDATA: ptr_r <= ptr_r + 8'h01;
          ST_RDATA: ;
          default:  ;
        endcase
      end
      if (load_rd) begin
        tx_r    <= rd_byte;
        ptr_r   <= ptr_r + 8'h01;
        state_r <= ST_RDATA;
      end else if (ack_end && state_r == ST_ADDR) begin
        state_r <= ST_OFFS;
      end else if (ack_end && state_r == ST_OFFS) begin
        state_r <= ST_WDATA;
      end
    end
  end

  // =====================================================================
  // register file
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `SCB_REG_COUNT; i++)
        regs_r[i] <= `SCB_ADDR_RESET;
    end else if (!start_ev && !stop_ev && byte_end && state_r == ST_WDATA
                 && ptr_r < 8'(`SCB_REG_COUNT)) begin
      regs_r[ptr_r[2:0]] <= shreg_r;
    end
  end

  // =====================================================================
  // open-drain line drive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe   <= 1'b0;
      sda_o    <= 1'b0;
      scl_o    <= 1'b0;
      scl_oe   <= 1'b0;
      bus_addr <= 7'h00;
    end else begin
      sda_o    <= 1'b0;
      scl_o    <= 1'b0;
      scl_oe   <= 1'b0;
      bus_addr <= own_addr;
      if (start_ev || stop_ev)
        sda_oe <= 1'b0;
      else if (do_ack)
        sda_oe <= 1'b1;
      else if (load_rd)
        sda_oe <= ~rd_byte[7];
      else if (state_r == ST_RDATA && scl_fall && cnt_r < `BIT_LAST)
        sda_oe <= ~tx_r[6];
      else if (state_r == ST_RDATA && byte_end)
        sda_oe <= 1'b0;
      else if (ack_end || state_r == ST_WAIT || state_r == ST_IDLE)
        sda_oe <= 1'b0;
    end
  end

  // =====================================================================
  // checks
  property p_stop_idle;
    @(posedge clk) disable iff (!arst_n) (stop_ev && !start_ev) |=> state_r == ST_IDLE && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not end transaction");

  property p_ack_match;
    @(posedge clk) disable iff (!arst_n)
      (state_r == ST_ADDR && byte_end && match && !start_ev && !stop_ev) |=> sda_oe ##1 sda_oe;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("own address not acknowledged");

  property p_nack_other;
    @(posedge clk) disable iff (!arst_n)
      (state_r == ST_ADDR && byte_end && !match && !start_ev && !stop_ev) |=> !sda_oe && state_r == ST_WAIT;
  endproperty
  a_nack_other: assert property (p_nack_other) else $error("foreign address acknowledged");

  property p_write_ack;
    @(posedge clk) disable iff (!arst_n)
      (state_r == ST_WDATA && byte_end && !start_ev && !stop_ev) |=> sda_oe;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write byte not acknowledged");

  property p_read_nack;
    @(posedge clk) disable iff (!arst_n)
      (state_r == ST_RDATA && scl_rise && cnt_r == `BIT_ACK && sda_s2_r && !start_ev && !stop_ev)
        |=> state_r == ST_WAIT && !sda_oe;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("read drive kept after host nack");

  property p_scl_free;
    @(posedge clk) disable iff (!arst_n) !scl_oe && !scl_o;
  endproperty
  a_scl_free: assert property (p_scl_free) else $error("clock line driven");

  property p_sda_low_only;
    @(posedge clk) disable iff (!arst_n) sda_oe |-> !sda_o;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("data line driven high");

  property p_drive_on_fall;
    @(posedge clk) disable iff (!arst_n)
      $rose(sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("data driven outside clock low");

  property p_override;
    @(posedge clk) disable iff (!arst_n)
      regs_r[0][`SCB_OVR_BIT] |=> bus_addr == $past(regs_r[0][7:1]);
  endproperty
  a_override: assert property (p_override) else $error("programmed address not in effect");

  c_write: cover property (@(posedge clk) disable iff (!arst_n) state_r == ST_WDATA && byte_end);
  c_read:  cover property (@(posedge clk) disable iff (!arst_n) load_rd && state_r == ST_RDATA);
  c_nack:  cover property (@(posedge clk) disable iff (!arst_n) state_r == ST_ADDR && byte_end && !match);

endmodule

// ===== testbench/i2c_host_model.sv
// behavioural two-wire host driving the bus by pulling lines low
`timescale 1ns/1ns
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl_low,
  output logic      sda_low
);
  int stretch = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // data changes only with the clock low, read mid high phase
  task automatic xbit(input logic b, output logic r);
    tick(3 + stretch);
    sda_low = !b;
    tick(1);
    scl_low = 1'b0;
    tick(2);
    r = sda_w;
    tick(2);
    scl_low = 1'b1;
  endtask
  task automatic start();
    tick(3);
    sda_low = 1'b0;
    tick(1);
    scl_low = 1'b0;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    tick(3);
    sda_low = 1'b1;
    tick(1);
    scl_low = 1'b0;
    tick(2);
    sda_low = 1'b0;
    tick(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, r);
  endtask
endmodule

// ===== testbench/test_serial_control_bus_target.sv
// self-checking bench for the serial control target
`timescale 1ns/1ns
module test_serial_control_bus_target;
  logic       clk;
  logic       arst_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic       scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low, hi_seen = 1'b0;
  logic [6:0] bus_addr;
  wire logic  scl_w = !(scl_low || (scl_oe && !scl_o));
  wire logic  sda_w = !(sda_low || (sda_oe && !sda_o));
  int         err_count = 0;
  int         num_checks = 0;
  int         seed = 80;
  int         cycles = 0;

  serial_control_bus_target u_dut (.clk(clk), .arst_n(arst_n), .address_strap_pin(strap), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .bus_addr(bus_addr));
  i2c_host_model u_host (.clk(clk), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (arst_n && (scl_oe !== 1'b0 || (sda_oe && sda_o !== 1'b0))) hi_seen <= 1'b1;
    if (cycles == 30000) begin
      err_count++;
      $display("timeout");
      summarize();
    end
  end
  // ==========================================
  // helpers
  function automatic logic [6:0] exp_addr(input logic [2:0] c);
    return 7'h0c + {3'h0, c, 1'b0};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic [2:0] c);
    arst_n = 1'b0;
    strap = c;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (60) @(negedge clk);
  endtask
  task automatic ping(input logic [6:0] a, input logic exp);
    logic k;
    u_host.start();
    u_host.wbyte({a, 1'b0}, k);
    u_host.stop();
    chk("address ack", {7'h0, exp}, {7'h0, k});
  endtask
  task automatic wr2(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1);
    logic k;
    u_host.start();
    u_host.wbyte({a, 1'b0}, k);
    chk("write address ack", 8'h1, {7'h0, k});
    u_host.wbyte(off, k);
    chk("offset ack", 8'h1, {7'h0, k});
    u_host.wbyte(d0, k);
    chk("data ack", 8'h1, {7'h0, k});
    u_host.wbyte(d1, k);
    chk("data ack", 8'h1, {7'h0, k});
    u_host.stop();
  endtask
  task automatic rd2(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d0, output logic [7:0] d1);
    logic k;
    u_host.start();
    u_host.wbyte({a, 1'b0}, k);
    u_host.wbyte(off, k);
    u_host.start();
    u_host.wbyte({a, 1'b1}, k);
    chk("read address ack", 8'h1, {7'h0, k});
    u_host.rbyte(1'b0, d0);
    u_host.rbyte(1'b1, d1);
    u_host.tick(5);
    chk("data drive after nack", 8'h0, {7'h0, sda_oe});
    u_host.stop();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    logic [7:0] off, d0, d1, r0, r1;
    logic       k;
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c));
      chk("strap address", {1'b0, exp_addr(3'(c))}, {1'b0, bus_addr});
      ping(exp_addr(3'(c)), 1'b1);
      ping(exp_addr(3'(c)) + 7'h02, 1'b0);
    end
    $display("test strap done");
    for (int i = 0; i < 6; i++) begin
      u_host.stretch = i % 2;
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      off = 8'h1 + {5'h0, d0[2:0] % 3'h6};
      wr2(7'h1a, off, d0, d1);
      rd2(7'h1a, off, r0, r1);
      chk("read byte", d0, r0);
      chk("read byte", d1, r1);
    end
    wr2(7'h1a, 8'h07, 8'h5a, 8'ha5);
    rd2(7'h1a, 8'h07, r0, r1);
    chk("last offset", 8'h5a, r0);
    chk("beyond map", 8'h00, r1);
    $display("test traffic done");
    wr2(7'h1a, 8'h00, {7'h21, 1'b1}, 8'h00);
    chk("programmed address", 8'h21, {1'b0, bus_addr});
    ping(7'h1a, 1'b0);
    ping(7'h21, 1'b1);
    wr2(7'h21, 8'h00, {7'h21, 1'b0}, 8'h00);
    chk("strap address back", 8'h1a, {1'b0, bus_addr});
    ping(7'h21, 1'b0);
    $display("test override done");
    u_host.start();
    for (int i = 0; i < 4; i++) u_host.xbit(1'b0, k);
    u_host.stop();
    ping(7'h1a, 1'b1);
    chk("lines never driven high", 8'h0, {7'h0, hi_seen});
    $display("test abort done");
    summarize();
  end
endmodule
